//--- sim/rfts_asserts.sv
// checker for the link between the two ends and the pin timing
// assumes: instanced in the bench beside the link, one clk domain
`timescale 1ns/1ps
module rfts_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        rxMode,
  input wire logic        rxBitStrobe,
  input wire logic        syncMatch,
  input wire logic [1:0]  pinMode,
  input wire logic [7:0]  packetBytes,
  input wire logic        divStrobe,
  input wire logic [15:0] frequencyErrorReadback
);
  logic [10:0] hiCnt_q;

  // ----
  // helper: bit strobes seen while the pin is high
  // ----
  // counts past 255 bytes are never reached, so 11 bits suffice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hiCnt_q <= 11'h000;
    else if (!syncMatch) hiCnt_q <= 11'h000;
    else if (rxBitStrobe) hiCnt_q <= hiCnt_q + 11'h001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----
  // properties
  // ----
  pin_rise_strobe_a: assert property ($rose(syncMatch) |-> $past(rxBitStrobe))
    else $error("pin rose away from a bit strobe");
  pin_fall_strobe_a: assert property ($fell(syncMatch) |-> $past(rxBitStrobe) || !$past(rxMode))
    else $error("pin fell away from a bit strobe");
  pin_enable_a: assert property ($rose(syncMatch) |-> $past(pinMode[0]))
    else $error("pin rose while disabled");
  single_bit_a: assert property (syncMatch && rxBitStrobe && rxMode
      && (!pinMode[1] || packetBytes == 8'h00) |=> !syncMatch)
    else $error("unframed pin longer than one bit");
  frame_len_a: assert property ($fell(syncMatch) && pinMode == 2'h3 && packetBytes != 8'h00
      && $past(rxMode) |-> hiCnt_q == {packetBytes, 3'h0})
    else $error("framed pin length differs from byte count");
  rx_clear_a: assert property (!rxMode |=> !syncMatch)
    else $error("pin high outside receive mode");
  readback_hold_a: assert property (!rxMode |=> $stable(frequencyErrorReadback))
    else $error("readback moved outside receive mode");
  div_pulse_a: assert property (divStrobe |=> !divStrobe)
    else $error("divider strobe longer than one cycle");
endmodule

//--- sim/rx_freq_track_and_sync_detect_tb.sv
// self-checking bench: host end and device end joined by the link
// assumes: the checker file is compiled alongside
`timescale 1ns/1ps
module rx_freq_track_and_sync_detect_tb;
  localparam logic [23:0] WORD = 24'h9c3ae5;
  logic clk, rst_n, rxMode, discValid, rxBit, rxBitStrobe;
  logic signed [15:0] discSample, divTrim;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_fail, cmp_count;

  rfts_link_if lnk();
  rfts_device u_rfts_device (.clk(clk), .rst_n(rst_n), .link(lnk), .rxMode(rxMode),
    .discSample(discSample), .discValid(discValid), .rxBit(rxBit),
    .rxBitStrobe(rxBitStrobe), .divTrim(divTrim));
  rfts_host u_rfts_host (.clk(clk), .rst_n(rst_n), .link(lnk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  rfts_asserts u_rfts_asserts (.clk(clk), .rst_n(rst_n), .rxMode(rxMode),
    .rxBitStrobe(rxBitStrobe), .syncMatch(lnk.syncMatch), .pinMode(lnk.pinMode),
    .packetBytes(lnk.packetBytes), .divStrobe(lnk.divStrobe),
    .frequencyErrorReadback(lnk.frequencyErrorReadback));

  always #2 clk = ~clk;

  // ----
  // shared tasks
  // ----
  task automatic end_of_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    n_fail++;
    end_of_test();
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    r = bresp;
    if (n >= 100) hang();
    // let an edge pass so a following call never re-raises bready in this step
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 100) hang();
    @(posedge clk);
  endtask

  task automatic wcfg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, 2'h0);
  endtask

  task automatic feed(input int n, input logic signed [15:0] s);
    discSample <= s;
    repeat (n) begin
      discValid <= 1'b1;
      @(posedge clk);
      discValid <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic sbit(input logic b);
    rxBit <= b;
    rxBitStrobe <= 1'b1;
    @(posedge clk);
    rxBitStrobe <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // restart the detector, then send the low bits of a word, msb first
  task automatic send_word(input int len, input logic [23:0] w);
    rxMode <= 1'b0;
    @(posedge clk);
    rxMode <= 1'b1;
    for (int i = 11 + 4 * len; i >= 0; i--) sbit(w[i]);
  endtask

  // ----
  // scenarios
  // ----
  task automatic reg_check();
    logic [31:0] d;
    logic [1:0] r;
    axr(8'h00, d, r);
    chk(d, 32'h0);
    axr(8'h40, d, r);
    chk(r, 2'h2);
    chk(d, 32'h0);
    axw(8'h40, 32'hffff_ffff, r);
    chk(r, 2'h2);
    axw(8'h18, 32'hffff_ffff, r);
    chk(r, 2'h0);
  endtask

  task automatic afc_ext();
    wcfg(8'h00, 32'hff00_0000);
    wcfg(8'h14, 32'h0000_0123);
    repeat (2) @(posedge clk);
    chk(divTrim, 16'h0123);
    feed(100, 16'sh7fff);
    chk(divTrim, 16'h0123);
  endtask

  task automatic afc_loop();
    // correlator bandwidth is set outside this block
    wcfg(8'h00, {8'h10, 7'h0, 12'h100, 1'b1, 4'h0});
    feed(300, 16'sh7fff);
    chk(divTrim, 32'h0000_0080);
    wcfg(8'h10, 32'h0004_0000);
    feed(50, 16'sh7fff);
    chk(divTrim, 32'h0000_0040);
  endtask

  task automatic frequency_error_readback();
    logic [31:0] d;
    logic [1:0] r;
    feed(300, 16'sh3333);
    chk(lnk.frequencyErrorReadback, 16'h3333);
    axr(8'h18, d, r);
    chk(d, 32'h0000_3333);
    rxMode <= 1'b0;
    feed(5, 16'sh0000);
    chk(lnk.frequencyErrorReadback, 16'h3333);
    rxMode <= 1'b1;
    // estimate below the IF: trim clamps at the negative limit
    feed(50, 16'sh0000);
    chk(divTrim, 32'hffff_ffc0);
  endtask

  task automatic sync_try(input int len, tol, errs, input logic [1:0] mode, input logic exp);
    logic [23:0] w;
    w = WORD ^ ((24'h1 << errs) - 24'h1);
    wcfg(8'h04, {24'h0, tol[1:0], len[1:0], 4'h0});
    wcfg(8'h08, {8'h0, WORD});
    wcfg(8'h0c, {16'h0, 8'h00, mode, 6'h00});
    send_word(len, w);
    chk(lnk.syncMatch, 1'b0);
    sbit(~w[0]);
    chk(lnk.syncMatch, exp);
    if (exp) begin
      sbit(1'b0);
      chk(lnk.syncMatch, 1'b0);
    end
  endtask

  task automatic frame_try();
    int n;
    logic [31:0] d;
    logic [1:0] r;
    wcfg(8'h04, 32'h0000_0030);
    wcfg(8'h0c, {16'h0, 8'h02, 2'h3, 6'h00});
    send_word(3, WORD);
    sbit(1'b1);
    chk(lnk.syncMatch, 1'b1);
    axr(8'h18, d, r);
    chk(r, 2'h0);
    chk(d[16], 1'b1);
    n = 0;
    while (lnk.syncMatch === 1'b1 && n < 40) begin
      sbit(1'b0);
      n++;
    end
    chk(n, 32'd16);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    rxMode = 1'b0;
    discValid = 1'b0;
    discSample = 16'sh0000;
    rxBit = 1'b0;
    rxBitStrobe = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rxMode <= 1'b1;
    @(posedge clk);
    reg_check();
    afc_ext();
    afc_loop();
    frequency_error_readback();
    for (int l = 0; l < 4; l++) begin
      sync_try(l, l, l, 2'h1, 1'b1);
      if (l < 3) sync_try(l, l, l + 1, 2'h1, 1'b0);
    end
    sync_try(3, 0, 0, 2'h0, 1'b0);
    frame_try();
    end_of_test();
  end
endmodule

//--- verilog/rfts_consts.svh
// constants of the receive frequency-tracking and sync-detect block
// assumes: included by bare name from the package and both ends
// ----------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------
`ifndef RFTS_CONSTS_SVH
`define RFTS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (host side, AXI4-Lite byte addresses)
// ----------------------------------------------------------------
`define RFTS_OFF_AFC      8'h00
`define RFTS_OFF_SYNCCFG  8'h04
`define RFTS_OFF_SYNCWORD 8'h08
`define RFTS_OFF_PKT      8'h0c
`define RFTS_OFF_RF       8'h10
`define RFTS_OFF_DIVWR    8'h14
`define RFTS_OFF_STATUS   8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RFTS_AFC_EN_BIT   4
`define RFTS_AFC_SCALE_LO 5
`define RFTS_AFC_SCALE_HI 16
`define RFTS_AFC_SPAN_LO  24
`define RFTS_AFC_SPAN_HI  31
`define RFTS_SYNC_LEN_LO  4
`define RFTS_SYNC_LEN_HI  5
`define RFTS_SYNC_TOL_LO  6
`define RFTS_SYNC_TOL_HI  7
`define RFTS_PIN_EN_BIT   6
`define RFTS_PIN_FRAME_BIT 7
`define RFTS_PKT_LEN_LO   8
`define RFTS_PKT_LEN_HI   15
`define RFTS_RF_HALF_BIT  18
`define RFTS_STAT_PIN_BIT 16

// ----------------------------------------------------------------
// reset values and timing figures
// ----------------------------------------------------------------
`define RFTS_RST_WORD     32'h0000_0000
`define RFTS_IF_HZ        100000
`define RFTS_READBACK_SHIFT 18
`define RFTS_AVG_SHIFT    4
`define RFTS_INTEG_SHIFT  12
`define RFTS_SPAN_SHIFT   4

`endif

//--- verilog/rfts_device.sv
// device end: AFC averaging/PI loop and sync word detector
// assumes: discriminator samples and recovered bits arrive on clk,
// each marked by a one-cycle strobe; configuration held by the host
`timescale 1ns/1ps
`include "rfts_consts.svh"
module rfts_device #(
  parameter int DEMOD_HZ = 2000000,
  parameter int AVG_SHIFT = `RFTS_AVG_SHIFT
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  rfts_link_if.device             link,
  input  wire logic               rxMode,
  input  wire logic signed [15:0] discSample,
  input  wire logic               discValid,
  input  wire logic               rxBit,
  input  wire logic               rxBitStrobe,
  output logic signed      [15:0] divTrim
);

  // ----------------------------------------------------------------
  // nominal IF code: readback * clock / 2^18 equals 100 kHz
  // ----------------------------------------------------------------
  localparam longint IF_CODE_L =
    (longint'(`RFTS_IF_HZ) << `RFTS_READBACK_SHIFT) / longint'(DEMOD_HZ);
  localparam logic signed [15:0] IF_CODE = 16'(IF_CODE_L);

  rfts_pkg::rfts_dev_state_t q;
  rfts_pkg::rfts_dev_state_t d;

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic        [23:0] lenMask;
  logic        [23:0] diffBits;
  logic        [4:0]  mismatches;
  logic        [23:0] nextHistory;
  logic               isMatch;
  logic signed [16:0] sampleDelta;
  logic signed [16:0] err;
  logic signed [31:0] product;
  logic signed [23:0] integNext;
  logic signed [23:0] trimRaw;
  logic signed [23:0] limit;
  logic        [7:0]  halfSpan;
  logic        [10:0] frameBits;

  always_comb begin
    unique case (rfts_pkg::rfts_synclen_t'(link.syncLenSel))
      rfts_pkg::RFTS_LEN12: lenMask = 24'h000fff;
      rfts_pkg::RFTS_LEN16: lenMask = 24'h00ffff;
      rfts_pkg::RFTS_LEN20: lenMask = 24'h0fffff;
      rfts_pkg::RFTS_LEN24: lenMask = 24'hffffff;
    endcase
  end

  // newest bit enters at the lsb, so an msb-first word lines up
  assign nextHistory = {q.history[22:0], rxBit};
  assign diffBits    = (nextHistory ^ link.syncWord) & lenMask;

  always_comb begin
    mismatches = 5'h00;
    for (int i = 0; i < 24; i++) begin
      mismatches = mismatches + 5'(diffBits[i]);
    end
  end

  // accept when errors stay within the programmed tolerance
  assign isMatch = (mismatches <= {3'h0, link.errTolerance});

  // ----------------------------------------------------------------
  // AFC arithmetic
  // ----------------------------------------------------------------
  // first-order average doubles as the envelope: fsk swings cancel
  assign sampleDelta = 17'(discSample) - 17'(q.avg);
  assign err         = 17'(q.avg) - 17'(IF_CODE);
  assign product     = 32'(err) * $signed({20'h00000, link.loopScale});
  assign integNext   = q.integ + 24'(product >>> `RFTS_INTEG_SHIFT);

  // span is total width; half applies each side, halved again under rf halving
  always_comb begin
    if (link.rfHalvingSelect) begin
      halfSpan = {2'h0, link.afcSpan[7:2]};
    end else begin
      halfSpan = {1'h0, link.afcSpan[7:1]};
    end
  end
  assign limit   = 24'({16'h0000, halfSpan} << `RFTS_SPAN_SHIFT);
  assign trimRaw = integNext + 24'(err >>> 2);

  assign frameBits = {link.packetBytes, 3'h0};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;

    // averaged estimate and signed readback
    if (rxMode && discValid) begin
      d.avg      = q.avg + 16'(sampleDelta >>> AVG_SHIFT);
      d.readback = q.avg;
    end

    // internal PI loop, clamped to the programmed span
    if (link.afcEnable) begin
      if (rxMode && discValid) begin
        if (integNext > limit) begin
          d.integ = limit;
        end else if (integNext < -limit) begin
          d.integ = -limit;
        end else begin
          d.integ = integNext;
        end
        if (trimRaw > limit) begin
          d.trim = 16'(limit);
        end else if (trimRaw < -limit) begin
          d.trim = 16'(-limit);
        end else begin
          d.trim = 16'(trimRaw);
        end
      end
    end else begin
      d.integ = 24'h000000;
      // external correction: host writes the divider trim directly
      if (link.divStrobe) begin
        d.trim = link.divValue;
      end
    end

    // sync detection, advanced once per recovered bit
    if (!rxMode) begin
      d.history  = 24'h000000;
      d.pending  = 1'b0;
      d.pin      = 1'b0;
      d.bitsLeft = 11'h000;
    end else if (rxBitStrobe) begin
      d.history = nextHistory;
      if (q.pin) begin
        // framing: hold for the packet, counted in bits
        if (q.bitsLeft > 11'h001) begin
          d.bitsLeft = q.bitsLeft - 11'h001;
        end else begin
          d.bitsLeft = 11'h000;
          d.pin      = 1'b0;
        end
      end else if (q.pending) begin
        // pin rises one bit clock after the match
        d.pending = 1'b0;
        d.pin     = link.pinMode[`RFTS_PIN_EN_BIT - 6];
        if (link.pinMode[`RFTS_PIN_FRAME_BIT - 6] && link.packetBytes != 8'h00) begin
          d.bitsLeft = frameBits;
        end else begin
          d.bitsLeft = 11'h001;
        end
      end
      // a fresh match while framing is ignored: the packet owns the pin
      if (!q.pin && !q.pending && isMatch) begin
        d.pending = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.frequencyErrorReadback = q.readback;
  assign link.syncMatch              = q.pin;
  assign divTrim                     = q.trim;

endmodule

//--- verilog/rfts_host.sv
// host end: AXI4-Lite register file that programs the device end
// assumes: software is the AXI4-Lite master on clk
`timescale 1ns/1ps
`include "rfts_consts.svh"
module rfts_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  rfts_link_if.host        link,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  rfts_pkg::rfts_host_state_t q;
  rfts_pkg::rfts_host_state_t d;

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
                                        logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.divStrobe = 1'b0;

    if (awvalid && !q.awHave) begin
      d.awHave = 1'b1;
      d.awAddr = awaddr;
    end
    if (wvalid && !q.wHave) begin
      d.wHave = 1'b1;
      d.wData = wdata;
      d.wStrb = wstrb;
    end

    // commit once address and data are both held
    if (q.awHave && q.wHave && !q.bvalid) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = 2'b00;
      unique case (q.awAddr)
        `RFTS_OFF_AFC:      d.afcCfg   = merge(q.afcCfg, q.wData, q.wStrb);
        `RFTS_OFF_SYNCCFG:  d.syncCfg  = merge(q.syncCfg, q.wData, q.wStrb);
        `RFTS_OFF_SYNCWORD: d.syncWord = merge(q.syncWord, q.wData, q.wStrb);
        `RFTS_OFF_PKT:      d.pktCfg   = merge(q.pktCfg, q.wData, q.wStrb);
        `RFTS_OFF_RF:       d.rfCfg    = merge(q.rfCfg, q.wData, q.wStrb);
        `RFTS_OFF_DIVWR: begin
          // external correction path toward the synthesizer divider
          d.divValue  = q.wData[15:0];
          d.divStrobe = 1'b1;
        end
        `RFTS_OFF_STATUS: ;
        default: d.bresp = 2'b10;
      endcase
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end

    unique case (q.rd)
      rfts_pkg::RFTS_RD_IDLE: begin
        if (arvalid) begin
          d.rd    = rfts_pkg::RFTS_RD_BUSY;
          d.rresp = 2'b00;
          unique case (araddr)
            `RFTS_OFF_AFC:      d.rdata = q.afcCfg;
            `RFTS_OFF_SYNCCFG:  d.rdata = q.syncCfg;
            `RFTS_OFF_SYNCWORD: d.rdata = q.syncWord;
            `RFTS_OFF_PKT:      d.rdata = q.pktCfg;
            `RFTS_OFF_RF:       d.rdata = q.rfCfg;
            `RFTS_OFF_DIVWR:    d.rdata = {16'h0000, q.divValue};
            `RFTS_OFF_STATUS:   d.rdata = {15'h0000, link.syncMatch,
                                           link.frequencyErrorReadback};
            default: begin
              d.rdata = 32'h0000_0000;
              d.rresp = 2'b10;
            end
          endcase
        end
      end
      rfts_pkg::RFTS_RD_BUSY: begin
        if (rready) begin
          d.rd = rfts_pkg::RFTS_RD_IDLE;
        end
      end
      default: d.rd = rfts_pkg::RFTS_RD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------
  assign awready = !q.awHave;
  assign wready  = !q.wHave;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = (q.rd == rfts_pkg::RFTS_RD_IDLE);
  assign rvalid  = (q.rd == rfts_pkg::RFTS_RD_BUSY);
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;

  // span programmed doubled by software under rf halving, kept within
  // 1.5 IF bandwidths; sync length 24 preferred
  assign link.afcEnable       = q.afcCfg[`RFTS_AFC_EN_BIT];
  assign link.loopScale       = q.afcCfg[`RFTS_AFC_SCALE_HI:`RFTS_AFC_SCALE_LO];
  assign link.afcSpan         = q.afcCfg[`RFTS_AFC_SPAN_HI:`RFTS_AFC_SPAN_LO];
  assign link.rfHalvingSelect = q.rfCfg[`RFTS_RF_HALF_BIT];
  assign link.syncWord        = q.syncWord[23:0];
  assign link.syncLenSel      = q.syncCfg[`RFTS_SYNC_LEN_HI:`RFTS_SYNC_LEN_LO];
  assign link.errTolerance    = q.syncCfg[`RFTS_SYNC_TOL_HI:`RFTS_SYNC_TOL_LO];
  assign link.pinMode         = q.pktCfg[`RFTS_PIN_FRAME_BIT:`RFTS_PIN_EN_BIT];
  assign link.packetBytes     = q.pktCfg[`RFTS_PKT_LEN_HI:`RFTS_PKT_LEN_LO];
  assign link.divValue        = q.divValue;
  assign link.divStrobe       = q.divStrobe;

endmodule

//--- verilog/rfts_link_if.sv
// link between the receive device end and its host controller end
// assumes: both ends run on the same clk
`timescale 1ns/1ps
interface rfts_link_if;
  logic               afcEnable;
  logic        [11:0] loopScale;
  logic        [7:0]  afcSpan;
  logic               rfHalvingSelect;
  logic        [23:0] syncWord;
  logic        [1:0]  syncLenSel;
  logic        [1:0]  errTolerance;
  logic        [1:0]  pinMode;
  logic        [7:0]  packetBytes;
  logic        [15:0] divValue;
  logic               divStrobe;
  logic        [15:0] frequencyErrorReadback;
  logic               syncMatch;

  modport device (
    input  afcEnable, loopScale, afcSpan, rfHalvingSelect, syncWord, syncLenSel,
    input  errTolerance, pinMode, packetBytes, divValue, divStrobe,
    output frequencyErrorReadback, syncMatch
  );
  modport host (
    output afcEnable, loopScale, afcSpan, rfHalvingSelect, syncWord, syncLenSel,
    output errTolerance, pinMode, packetBytes, divValue, divStrobe,
    input  frequencyErrorReadback, syncMatch
  );
endinterface

//--- verilog/rfts_pkg.sv
// types for the two ends of the frequency-tracking/sync block, each type used by one end only
// assumes: the constants header sits beside it
`include "rfts_consts.svh"
package rfts_pkg;

  typedef enum logic [1:0] {
    RFTS_LEN12,
    RFTS_LEN16,
    RFTS_LEN20,
    RFTS_LEN24
  } rfts_synclen_t;

  typedef struct packed {
    logic signed [15:0] avg;
    logic signed [23:0] integ;
    logic signed [15:0] trim;
    logic        [15:0] readback;
    logic        [23:0] history;
    logic               pending;
    logic               pin;
    logic        [10:0] bitsLeft;
  } rfts_dev_state_t;

  typedef enum logic [1:0] {
    RFTS_RD_IDLE,
    RFTS_RD_BUSY
  } rfts_rd_t;

  typedef struct packed {
    logic [31:0] afcCfg;
    logic [31:0] syncCfg;
    logic [31:0] syncWord;
    logic [31:0] pktCfg;
    logic [31:0] rfCfg;
    logic [15:0] divValue;
    logic        divStrobe;
    logic        awHave;
    logic [7:0]  awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    rfts_rd_t    rd;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rfts_host_state_t;

endpackage
